// *** verilog/bmsl_loader.sv ***
// Mode strap decode and serial boot loader with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "bmsl_regs.svh"
// Summary of operation
// - Mode taken from straps at reset end: user, boot, programmer, or none when no strap pattern matches.
// - Boot mode loads program into RAM, erases whole flash, then branches.
// - Boot link is asynchronous, eight data bits, one stop, no parity.
// - Serial lines are not inverted on either side.
// - Host sends zero bytes; device times the low period to set baud.
// - About one hundred states of preparation precede the low measurement.
// - Device sends one zero byte when matched; host answers with 0x55.
// - Program bytes land in RAM window 0xF780 through 0xFEEF.
// - At handoff receive and transmit enables clear; divisor is kept.
// - Watchdog overflow ends boot mode just like reset.
// - Flash reads are blocked while erase runs.
// - Loader RAM stays reserved until the loaded program takes over.
module bmsl_loader #(
  parameter int DIV_W = 17,
  parameter int ADDR_W = 12
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic wdt_overflow_in,
  input wire logic test_pin_in,
  input wire logic boot_select_pin_in,
  input wire logic boot_confirm_pin_in,
  input wire logic programmer_select_pin_a_in,
  input wire logic programmer_select_pin_b_in,
  input wire logic programmer_select_pin_c_in,
  input wire logic rxd_in,
  output logic txd_out,
  output logic txd_oe_out,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic ram_we_out,
  output logic [15:0] ram_addr_out,
  output logic [7:0] ram_wdata_out,
  output logic ram_reserved_out,
  output logic flash_erase_req_out,
  input wire logic flash_erase_done_in,
  output logic flash_read_block_out,
  output logic branch_out,
  output var bmsl_pkg::bmsl_mode_e mode_out
);
  import bmsl_pkg::*;

  logic rst_ok;
  logic [6:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q, pin_f_d;
  logic rx_f;
  bmsl_state_e state_q, state_d;
  bmsl_mode_e mode_q, mode_d;
  logic started_q, started_d;
  logic [DIV_W-1:0] cnt_q, cnt_d, div_q, div_d;
  logic [3:0] nine_q, nine_d;
  logic [15:0] len_q, len_d, addr_q, addr_d, ram_addr_q, ram_addr_d;
  logic [7:0] ram_wdata_q, ram_wdata_d, rxbuf_q, rxbuf_d;
  logic re_q, re_d, te_q, te_d;
  logic ram_we_q, ram_we_d, reserved_q, reserved_d, erase_q, erase_d;
  logic block_q, block_d, branch_q, branch_d, oe_q, oe_d;
  logic ferr_q, ferr_d, rxf_q, rxf_d, ovf_q, ovf_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d, txd_q;
  logic tx_go;
  logic [7:0] tx_byte;
  logic uart_txd;
  logic setup, acc_wr, acc_rd, sw_owns;
  logic [15:0] len_full;

  bmsl_ser_if #(.DIV_W(DIV_W)) ser ();

  // Watchdog overflow ends boot exactly as reset does
  assign rst_ok = rst_b_in & ~wdt_overflow_in;

  // Pins cross in through three flops; a change counts once stages two and three agree
  always_ff @(posedge clk_in)
  begin
    pin_s1_q <= {test_pin_in, boot_select_pin_in, boot_confirm_pin_in, programmer_select_pin_a_in,
                 programmer_select_pin_b_in, programmer_select_pin_c_in, rxd_in};
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
    pin_f_q <= pin_f_d;
  end

  always_comb
  begin
    for (int i = 0; i < 7; i++)
      pin_f_d[i] = (pin_s2_q[i] == pin_s3_q[i]) ? pin_s3_q[i] : pin_f_q[i];
  end

  // Line taken as is, no inversion stage
  assign rx_f = pin_f_q[0];
  assign len_full = {len_q[15:8], ser.rx_data};

  assign ser.divisor = div_q;
  assign ser.rx_en = re_q;
  assign ser.tx_en = te_q;
  assign ser.tx_valid = tx_go;
  assign ser.tx_data = tx_byte;

  // Fixed 8N1 framing in the engine
  bmsl_uart #(.DIV_W(DIV_W)) u_uart (
    .clk_in(clk_in),
    .rst_b_in(rst_ok),
    .rxd_in(rx_f),
    .txd_out(uart_txd),
    .ser(ser)
  );

  // APB phase decode; sync chain runs through reset so straps are settled at release
  assign setup = psel_in & ~penable_in;
  assign acc_wr = psel_in & penable_in & pready_q & pwrite_in;
  assign acc_rd = psel_in & penable_in & pready_q & ~pwrite_in;
  // Software owns the serial unit once the loaded program runs, and in idle outside boot mode
  assign sw_owns = (state_q == BMSL_ST_RUN) || (state_q == BMSL_ST_IDLE);

  always_comb
  begin
    state_d = state_q;
    mode_d = mode_q;
    started_d = 1'b1;
    cnt_d = cnt_q;
    nine_d = nine_q;
    div_d = div_q;
    len_d = len_q;
    addr_d = addr_q;
    ram_addr_d = ram_addr_q;
    ram_wdata_d = ram_wdata_q;
    re_d = re_q;
    te_d = te_q;
    ram_we_d = 1'b0;
    reserved_d = reserved_q;
    erase_d = erase_q;
    block_d = block_q;
    branch_d = 1'b0;
    oe_d = oe_q;
    ovf_d = ovf_q;
    tx_go = 1'b0;
    tx_byte = `BMSL_ACK_BYTE;
    if (!started_q)
    begin
      cnt_d = '0;
      state_d = BMSL_ST_IDLE;
      if (!pin_f_d[6] && pin_f_d[5])
        mode_d = BMSL_MODE_USER;
      else if (!pin_f_d[6] && !pin_f_d[5] && pin_f_d[4])
      begin
        mode_d = BMSL_MODE_BOOT;
        state_d = BMSL_ST_PREP;
        reserved_d = 1'b1;
        oe_d = 1'b1;
      end
      else if (pin_f_d[6] && pin_f_d[3:1] == 3'b000)
        mode_d = BMSL_MODE_PROG;
      else
        mode_d = BMSL_MODE_NONE;
    end
    else
    begin
      case (state_q)
        BMSL_ST_PREP:
        begin
          // Preparation delay before timing starts
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == `BMSL_PREP_CNT)
          begin
            state_d = BMSL_ST_LOW;
            re_d = 1'b1;
            te_d = 1'b1;
          end
        end
        BMSL_ST_LOW:
          if (!rx_f)
          begin
            state_d = BMSL_ST_MEAS;
            cnt_d = '0;
            nine_d = 4'd1;
          end
        BMSL_ST_MEAS:
          // Low time divided by nine, start bit plus eight zero data bits
          if (!rx_f)
          begin
            if (nine_q == `BMSL_NINE_LAST)
            begin
              nine_d = 4'd0;
              if (!(&cnt_q))
                cnt_d = cnt_q + 1'b1;
            end
            else
              nine_d = nine_q + 1'b1;
          end
          else if (cnt_q == '0)
            state_d = BMSL_ST_LOW;
          else
          begin
            div_d = cnt_q;
            state_d = BMSL_ST_ACK;
          end
        BMSL_ST_ACK:
          // One zero byte marks the match
          if (ser.tx_ready)
          begin
            tx_go = 1'b1;
            state_d = BMSL_ST_SYNC;
          end
        BMSL_ST_SYNC:
          // Trailing zero bytes are ignored until the answer arrives
          if (ser.rx_valid && !ser.rx_err && ser.rx_data == `BMSL_SYNC_BYTE)
            state_d = BMSL_ST_LENH;
        BMSL_ST_LENH:
          if (ser.rx_valid)
          begin
            len_d = {ser.rx_data, 8'h00};
            state_d = BMSL_ST_LENL;
          end
        BMSL_ST_LENL:
          if (ser.rx_valid)
          begin
            // Longer programs are cut at the window end
            len_d = (len_full > `BMSL_RAM_SIZE) ? `BMSL_RAM_SIZE : len_full;
            ovf_d = len_full > `BMSL_RAM_SIZE;
            addr_d = `BMSL_RAM_BASE;
            state_d = (len_full == 16'h0000) ? BMSL_ST_ERASE : BMSL_ST_LOAD;
          end
        BMSL_ST_LOAD:
          if (ser.rx_valid)
          begin
            ram_we_d = 1'b1;
            ram_addr_d = addr_q;
            ram_wdata_d = ser.rx_data;
            addr_d = addr_q + 16'h0001;
            len_d = len_q - 16'h0001;
            if (len_q == 16'h0001)
              state_d = BMSL_ST_ERASE;
          end
        BMSL_ST_ERASE:
        begin
          // Whole array erased only after the load; reads fenced meanwhile
          erase_d = 1'b1;
          block_d = 1'b1;
          if (erase_q && flash_erase_done_in)
          begin
            erase_d = 1'b0;
            block_d = 1'b0;
            state_d = BMSL_ST_HAND;
          end
        end
        BMSL_ST_HAND:
        begin
          // Link stops, divisor stays; pin left output and high
          re_d = 1'b0;
          te_d = 1'b0;
          oe_d = 1'b1;
          reserved_d = 1'b0;
          branch_d = 1'b1;
          state_d = BMSL_ST_RUN;
        end
        BMSL_ST_RUN, BMSL_ST_IDLE:
        begin
          if (acc_wr && paddr_in == `BMSL_OFS_SCR)
          begin
            re_d = pwdata_in[`BMSL_SCR_RE];
            te_d = pwdata_in[`BMSL_SCR_TE];
          end
          if (acc_wr && paddr_in == `BMSL_OFS_BAUD && pwdata_in[DIV_W-1:0] != '0)
            div_d = pwdata_in[DIV_W-1:0];
          if (acc_wr && paddr_in == `BMSL_OFS_DATA && ser.tx_ready)
          begin
            tx_go = 1'b1;
            tx_byte = pwdata_in[7:0];
          end
        end
        default:
          state_d = BMSL_ST_IDLE;
      endcase
    end
  end

  // Status flags: hardware set wins over a clear in the same cycle
  always_comb
  begin
    ferr_d = ferr_q;
    rxf_d = rxf_q;
    rxbuf_d = rxbuf_q;
    if (acc_wr && paddr_in == `BMSL_OFS_STAT && pwdata_in[`BMSL_STAT_FERR])
      ferr_d = 1'b0;
    if (acc_rd && paddr_in == `BMSL_OFS_DATA)
      rxf_d = 1'b0;
    if (ser.rx_valid && ser.rx_err)
      ferr_d = 1'b1;
    if (ser.rx_valid && sw_owns)
    begin
      rxf_d = 1'b1;
      rxbuf_d = ser.rx_data;
    end
    pready_d = setup;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    if (setup)
    begin
      case (paddr_in)
        `BMSL_OFS_SCR:
        begin
          prdata_d[`BMSL_SCR_RE] = re_q;
          prdata_d[`BMSL_SCR_TE] = te_q;
        end
        `BMSL_OFS_BAUD:
          prdata_d[DIV_W-1:0] = div_q;
        `BMSL_OFS_STAT:
          prdata_d = {20'h00000, 1'b0, ovf_q, rxf_q, ferr_q, mode_q, 2'b00, state_q};
        `BMSL_OFS_DATA:
          prdata_d[7:0] = rxbuf_q;
        default:
          pslverr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_ok)
    begin
      state_q <= BMSL_ST_IDLE;
      mode_q <= BMSL_MODE_NONE;
      started_q <= 1'b0;
      cnt_q <= '0;
      nine_q <= 4'd0;
      div_q <= `BMSL_DIV_RST;
      len_q <= 16'h0000;
      addr_q <= `BMSL_RAM_BASE;
      ram_addr_q <= `BMSL_RAM_BASE;
      ram_wdata_q <= 8'h00;
      re_q <= 1'b0;
      te_q <= 1'b0;
      ram_we_q <= 1'b0;
      reserved_q <= 1'b0;
      erase_q <= 1'b0;
      block_q <= 1'b0;
      branch_q <= 1'b0;
      oe_q <= 1'b0;
      ovf_q <= 1'b0;
      ferr_q <= 1'b0;
      rxf_q <= 1'b0;
      rxbuf_q <= 8'h00;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      txd_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      mode_q <= mode_d;
      started_q <= started_d;
      cnt_q <= cnt_d;
      nine_q <= nine_d;
      div_q <= div_d;
      len_q <= len_d;
      addr_q <= addr_d;
      ram_addr_q <= ram_addr_d;
      ram_wdata_q <= ram_wdata_d;
      re_q <= re_d;
      te_q <= te_d;
      ram_we_q <= ram_we_d;
      reserved_q <= reserved_d;
      erase_q <= erase_d;
      block_q <= block_d;
      branch_q <= branch_d;
      oe_q <= oe_d;
      ovf_q <= ovf_d;
      ferr_q <= ferr_d;
      rxf_q <= rxf_d;
      rxbuf_q <= rxbuf_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      txd_q <= uart_txd;
    end
  end

  assign txd_out = txd_q;
  assign txd_oe_out = oe_q;
  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign ram_we_out = ram_we_q;
  assign ram_addr_out = ram_addr_q;
  assign ram_wdata_out = ram_wdata_q;
  assign ram_reserved_out = reserved_q;
  assign flash_erase_req_out = erase_q;
  assign flash_read_block_out = block_q;
  assign branch_out = branch_q;
  assign mode_out = mode_q;
endmodule : bmsl_loader
`default_nettype wire

// *** pkg/bmsl_regs.svh ***
// Boot loader register offsets, field positions and timing counts
`ifndef BMSL_REGS_SVH
`define BMSL_REGS_SVH
`define BMSL_OFS_SCR 12'h000
`define BMSL_OFS_BAUD 12'h004
`define BMSL_OFS_STAT 12'h008
`define BMSL_OFS_DATA 12'h00c
`define BMSL_SCR_RE 0
`define BMSL_SCR_TE 1
`define BMSL_STAT_FERR 8
`define BMSL_STAT_RXF 9
`define BMSL_STAT_OVF 10
`define BMSL_PREP_STATES 100
`define BMSL_PREP_CNT 17'd99
`define BMSL_NINE_LAST 4'd8
`define BMSL_ACK_BYTE 8'h00
`define BMSL_SYNC_BYTE 8'h55
`define BMSL_RAM_BASE 16'hf780
`define BMSL_RAM_LAST 16'hfeef
`define BMSL_RAM_SIZE 16'h0770
`define BMSL_DIV_RST 17'h00001
`endif

// *** pkg/bmsl_pkg.sv ***
// Boot loader types
`default_nettype none
package bmsl_pkg;
  typedef enum logic [3:0] {
    BMSL_ST_PREP  = 4'h0,
    BMSL_ST_LOW   = 4'h1,
    BMSL_ST_MEAS  = 4'h3,
    BMSL_ST_ACK   = 4'h2,
    BMSL_ST_SYNC  = 4'h6,
    BMSL_ST_LENH  = 4'h7,
    BMSL_ST_LENL  = 4'h5,
    BMSL_ST_LOAD  = 4'h4,
    BMSL_ST_ERASE = 4'hc,
    BMSL_ST_HAND  = 4'hd,
    BMSL_ST_RUN   = 4'hf,
    BMSL_ST_IDLE  = 4'he
  } bmsl_state_e;
  typedef enum logic [1:0] {
    BMSL_MODE_NONE = 2'h0,
    BMSL_MODE_USER = 2'h1,
    BMSL_MODE_BOOT = 2'h2,
    BMSL_MODE_PROG = 2'h3
  } bmsl_mode_e;
endpackage : bmsl_pkg
`default_nettype wire

// *** pkg/bmsl_ser_if.sv ***
// Link between loader control and its serial engine
`timescale 1ns/1ps
`default_nettype none
interface bmsl_ser_if #(parameter int DIV_W = 17);
  logic [DIV_W-1:0] divisor;
  logic rx_en;
  logic tx_en;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_ready;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_err;
  modport ctrl (output divisor, rx_en, tx_en, tx_valid, tx_data, input tx_ready, rx_valid, rx_data, rx_err);
  modport uart (input divisor, rx_en, tx_en, tx_valid, tx_data, output tx_ready, rx_valid, rx_data, rx_err);
endinterface : bmsl_ser_if
`default_nettype wire

// *** verilog/bmsl_uart.sv ***
// Asynchronous serial engine: 8 data bits, 1 stop bit, no parity
`timescale 1ns/1ps
`default_nettype none
module bmsl_uart #(parameter int DIV_W = 17) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic rxd_in,
  output logic txd_out,
  bmsl_ser_if.uart ser
);
  logic tx_busy_q, tx_busy_d, txd_q, txd_d;
  logic [8:0] tx_shift_q, tx_shift_d;
  logic [3:0] tx_bit_q, tx_bit_d;
  logic [DIV_W-1:0] tx_cnt_q, tx_cnt_d;
  logic rx_busy_q, rx_busy_d, rx_prev_q, rx_valid_q, rx_valid_d, rx_err_q, rx_err_d;
  logic [7:0] rx_shift_q, rx_shift_d;
  logic [3:0] rx_bit_q, rx_bit_d;
  logic [DIV_W-1:0] rx_cnt_q, rx_cnt_d;

  assign ser.tx_ready = ser.tx_en & ~tx_busy_q;
  assign ser.rx_valid = rx_valid_q;
  assign ser.rx_data = rx_shift_q;
  assign ser.rx_err = rx_err_q;
  assign txd_out = txd_q;

  always_comb
  begin
    tx_busy_d = tx_busy_q;
    txd_d = txd_q;
    tx_shift_d = tx_shift_q;
    tx_bit_d = tx_bit_q;
    tx_cnt_d = tx_cnt_q;
    if (!ser.tx_en)
    begin
      // Idle line stays high so the pin rests at mark
      tx_busy_d = 1'b0;
      txd_d = 1'b1;
    end
    else if (!tx_busy_q)
    begin
      if (ser.tx_valid)
      begin
        tx_busy_d = 1'b1;
        txd_d = 1'b0;
        tx_shift_d = {1'b1, ser.tx_data};
        tx_bit_d = 4'd9;
        tx_cnt_d = ser.divisor - 1'b1;
      end
    end
    else if (tx_cnt_q != '0)
      tx_cnt_d = tx_cnt_q - 1'b1;
    else if (tx_bit_q == 4'd0)
      tx_busy_d = 1'b0;
    else
    begin
      txd_d = tx_shift_q[0];
      tx_shift_d = {1'b1, tx_shift_q[8:1]};
      tx_bit_d = tx_bit_q - 1'b1;
      tx_cnt_d = ser.divisor - 1'b1;
    end
  end

  always_comb
  begin
    rx_busy_d = rx_busy_q;
    rx_shift_d = rx_shift_q;
    rx_bit_d = rx_bit_q;
    rx_cnt_d = rx_cnt_q;
    rx_valid_d = 1'b0;
    rx_err_d = 1'b0;
    if (!ser.rx_en)
      rx_busy_d = 1'b0;
    else if (!rx_busy_q)
    begin
      if (rx_prev_q && !rxd_in)
      begin
        rx_busy_d = 1'b1;
        rx_bit_d = 4'd0;
        rx_cnt_d = ser.divisor >> 1;
      end
    end
    else if (rx_cnt_q != '0)
      rx_cnt_d = rx_cnt_q - 1'b1;
    else
    begin
      rx_cnt_d = ser.divisor - 1'b1;
      rx_bit_d = rx_bit_q + 1'b1;
      if (rx_bit_q == 4'd0 && rxd_in)
        rx_busy_d = 1'b0;
      else if (rx_bit_q == 4'd9)
      begin
        rx_busy_d = 1'b0;
        rx_valid_d = 1'b1;
        rx_err_d = ~rxd_in;
      end
      else if (rx_bit_q != 4'd0)
        rx_shift_d = {rxd_in, rx_shift_q[7:1]};
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      tx_busy_q <= 1'b0;
      txd_q <= 1'b1;
      tx_shift_q <= '1;
      tx_bit_q <= 4'd0;
      tx_cnt_q <= '0;
      rx_busy_q <= 1'b0;
      rx_prev_q <= 1'b1;
      rx_shift_q <= 8'h00;
      rx_bit_q <= 4'd0;
      rx_cnt_q <= '0;
      rx_valid_q <= 1'b0;
      rx_err_q <= 1'b0;
    end
    else
    begin
      tx_busy_q <= tx_busy_d;
      txd_q <= txd_d;
      tx_shift_q <= tx_shift_d;
      tx_bit_q <= tx_bit_d;
      tx_cnt_q <= tx_cnt_d;
      rx_busy_q <= rx_busy_d;
      rx_prev_q <= rxd_in;
      rx_shift_q <= rx_shift_d;
      rx_bit_q <= rx_bit_d;
      rx_cnt_q <= rx_cnt_d;
      rx_valid_q <= rx_valid_d;
      rx_err_q <= rx_err_d;
    end
  end
endmodule : bmsl_uart
`default_nettype wire

// *** verification/bmsl_host.sv ***
// Host model driving the serial boot link
`timescale 1ns/1ps
`default_nettype none
module bmsl_host #(parameter int BIT = 36) (
  input wire logic clk_in,
  input wire logic txd_in,
  output logic rxd_out
);
  logic got_ack = 1'b0;
  logic [7:0] ack_byte;
  // Idles high as a pull-up would hold it
  initial rxd_out = 1'b1;
  // BIT stands for a supported rate and clock pair
  task automatic send(input logic [7:0] b); // 8N1, not inverted
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd_out <= f[i];
      repeat (BIT) @(posedge clk_in);
    end
  endtask : send
  // Samples mid bit; the device answers at the host rate
  always @(negedge txd_in)
  begin
    repeat (BIT / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge clk_in);
      ack_byte[i] = txd_in;
    end
    repeat (BIT) @(posedge clk_in);
    got_ack = (ack_byte === 8'h00) && (txd_in === 1'b1);
  end
  task automatic boot(input logic [7:0] prog[$]);
    // Bounded so a lost completion byte hands control back to the bench
    for (int k = 0; k < 8 && !got_ack; k++)
      send(8'h00);
    if (!got_ack)
      return;
    send(8'h55);
    send(8'(prog.size() >> 8));
    send(8'(prog.size()));
    foreach (prog[i])
      send(prog[i]);
  endtask : boot
endmodule : bmsl_host
`default_nettype wire

// *** verification/bmsl_loader_chk.sv ***
// Port-level assertions for the boot loader
`timescale 1ns/1ps
`default_nettype none
`include "bmsl_regs.svh"
module bmsl_loader_chk
  import bmsl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic wdt_overflow_in,
  input wire logic test_pin_in,
  input wire logic boot_select_pin_in,
  input wire logic boot_confirm_pin_in,
  input wire logic programmer_select_pin_a_in,
  input wire logic programmer_select_pin_b_in,
  input wire logic programmer_select_pin_c_in,
  input wire logic txd_out,
  input wire logic txd_oe_out,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pready_out,
  input wire logic ram_we_out,
  input wire logic [15:0] ram_addr_out,
  input wire logic ram_reserved_out,
  input wire logic flash_erase_req_out,
  input wire logic flash_read_block_out,
  input wire logic branch_out,
  input wire bmsl_pkg::bmsl_mode_e mode_out
);
  import bmsl_pkg::*;
  bmsl_mode_e exp_mode;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  always_comb
  begin
    if (!test_pin_in && boot_select_pin_in)
      exp_mode = BMSL_MODE_USER;
    else if (!test_pin_in && boot_confirm_pin_in)
      exp_mode = BMSL_MODE_BOOT;
    else if (test_pin_in && !(programmer_select_pin_a_in | programmer_select_pin_b_in | programmer_select_pin_c_in))
      exp_mode = BMSL_MODE_PROG;
    else
      exp_mode = BMSL_MODE_NONE;
  end
  a_reset_idle: assert property ($rose(rst_b_in) |-> mode_out == BMSL_MODE_NONE && txd_out && !txd_oe_out)
    else $error("outputs not idle after reset");
  a_mode_decode: assert property ($rose(rst_b_in) |=> mode_out == exp_mode)
    else $error("mode does not follow straps");
  a_boot_oe: assert property ($rose(rst_b_in) ##1 mode_out == BMSL_MODE_BOOT |=> txd_oe_out)
    else $error("tx pin not driven in boot");
  a_apb_ready: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready in access cycle");
  a_ram_window: assert property (ram_we_out |-> ram_reserved_out && ram_addr_out >= `BMSL_RAM_BASE && ram_addr_out <= `BMSL_RAM_LAST)
    else $error("ram write outside window");
  a_erase_block: assert property (flash_erase_req_out |-> flash_read_block_out && !ram_we_out)
    else $error("flash readable during erase");
  a_branch_after: assert property ($fell(flash_erase_req_out) && !$past(wdt_overflow_in) |=> branch_out ##1 !branch_out)
    else $error("no single branch after erase");
  a_erase_first: assert property (branch_out |-> $past(flash_read_block_out, 2))
    else $error("branch without erase");
  a_handoff_pins: assert property (branch_out |-> txd_out && txd_oe_out && !ram_reserved_out)
    else $error("pins wrong at handoff");
  a_wdt_clear: assert property (wdt_overflow_in |=> mode_out == BMSL_MODE_NONE && !branch_out && !ram_reserved_out)
    else $error("watchdog did not clear");
endmodule : bmsl_loader_chk
bind bmsl_loader bmsl_loader_chk u_chk (.clk_in, .rst_b_in, .wdt_overflow_in, .test_pin_in, .boot_select_pin_in,
  .boot_confirm_pin_in, .programmer_select_pin_a_in, .programmer_select_pin_b_in, .programmer_select_pin_c_in,
  .txd_out, .txd_oe_out, .psel_in, .penable_in, .pready_out, .ram_we_out, .ram_addr_out, .ram_reserved_out,
  .flash_erase_req_out, .flash_read_block_out, .branch_out, .mode_out);
`default_nettype wire

// *** verification/bmsl_loader_bench.sv ***
// Self-checking bench for the boot loader
`timescale 1ns/1ps
`default_nettype none
`include "bmsl_regs.svh"
module bmsl_loader_bench;
  import bmsl_pkg::*;
  localparam int BIT = 36;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic wdt_overflow_in = 1'b0;
  logic [5:0] strap = 6'b001000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic erase_done = 1'b0;
  logic [7:0] ecnt = 8'h00;
  logic rxd, txd, txd_oe, pready, pslverr, ram_we, reserved, erase_req, block, branch;
  logic [31:0] prdata;
  logic [15:0] ram_addr;
  logic [7:0] ram_wdata;
  bmsl_mode_e mode;
  logic [23:0] ram_log[$];
  int failures = 0;
  int check_count = 0;
  always #5 clk_in = ~clk_in;
  bmsl_loader u_dut (.clk_in, .rst_b_in, .wdt_overflow_in, .test_pin_in(strap[5]), .boot_select_pin_in(strap[4]),
    .boot_confirm_pin_in(strap[3]), .programmer_select_pin_a_in(strap[2]), .programmer_select_pin_b_in(strap[1]),
    .programmer_select_pin_c_in(strap[0]), .rxd_in(rxd), .txd_out(txd), .txd_oe_out(txd_oe), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .ram_we_out(ram_we), .ram_addr_out(ram_addr),
    .ram_wdata_out(ram_wdata), .ram_reserved_out(reserved), .flash_erase_req_out(erase_req),
    .flash_erase_done_in(erase_done), .flash_read_block_out(block), .branch_out(branch), .mode_out(mode));
  bmsl_host #(.BIT(BIT)) u_host (.clk_in, .txd_in(txd), .rxd_out(rxd));
  // Flash answers an erase after 20 cycles; RAM writes are logged
  always @(posedge clk_in)
  begin
    ecnt <= erase_req ? ecnt + 8'h01 : 8'h00;
    erase_done <= (ecnt == 8'd20);
    if (ram_we === 1'b1)
      ram_log.push_back({ram_addr, ram_wdata});
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] xr,
      input logic xe);
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1 && n++ < 50)
      @(posedge clk_in);
    r = prdata;
    e = pslverr;
    chk(pready, 1'b1, "ready");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
    if (!w)
      chk(r, xr, "read data");
    chk(e, xe, "slave error");
  endtask : xfer
  task automatic rst(input logic [5:0] s, input int n);
    strap <= s;
    rst_b_in <= 1'b0;
    repeat (n) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
  endtask : rst
  task automatic t_modes();
    logic [5:0] s [5] = '{6'b010000, 6'b001000, 6'b111000, 6'b100100, 6'b000000};
    bmsl_mode_e m [5] = '{BMSL_MODE_USER, BMSL_MODE_BOOT, BMSL_MODE_PROG, BMSL_MODE_NONE, BMSL_MODE_NONE};
    for (int i = 0; i < 5; i++)
    begin
      rst(s[i], 20);
      chk(mode, m[i], "mode");
      chk(txd_oe, m[i] == BMSL_MODE_BOOT, "tx enable");
    end
    $display("t_modes done");
  endtask : t_modes
  task automatic t_regs();
    rst(6'b010000, 20);
    xfer(0, `BMSL_OFS_STAT, 0, 32'h4e, 0);
    xfer(0, `BMSL_OFS_BAUD, 0, 32'h1, 0);
    xfer(1, `BMSL_OFS_BAUD, 32'h12345, 0, 0);
    xfer(1, `BMSL_OFS_BAUD, 32'h0, 0, 0);
    xfer(0, `BMSL_OFS_BAUD, 0, 32'h12345, 0);
    xfer(1, `BMSL_OFS_SCR, 32'h3, 0, 0);
    xfer(0, `BMSL_OFS_SCR, 0, 32'h3, 0);
    xfer(0, 12'h010, 0, 32'h0, 1);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_boot();
    // Stand-in image; real code sets up its registers and stack pointer first
    logic [7:0] prog[$] = '{8'ha5, 8'h3c, 8'h81};
    int n;
    n = 0;
    rst(6'b001000, 20);
    chk(reserved, 1, "reserved");
    // Host waits out the preparation span
    repeat (110) @(posedge clk_in);
    ram_log.delete();
    u_host.boot(prog);
    if (u_host.got_ack !== 1'b1)
    begin
      // No clean completion byte: restart boot by reset
      rst(6'b001000, 20);
      repeat (110) @(posedge clk_in);
      ram_log.delete();
      u_host.boot(prog);
    end
    chk(u_host.got_ack, 1, "completion byte");
    while (branch !== 1'b1 && n++ < 5000)
      @(posedge clk_in);
    chk(branch, 1, "branch");
    chk(txd, 1, "tx level");
    chk(txd_oe, 1, "tx enable");
    chk(reserved, 0, "released");
    chk(ram_log.size(), 3, "byte count");
    foreach (prog[i])
      chk(ram_log[i], {16'hf780 + 16'(i), prog[i]}, "ram write");
    xfer(0, `BMSL_OFS_SCR, 0, 32'h0, 0);
    xfer(0, `BMSL_OFS_BAUD, 0, BIT, 0);
    $display("t_boot done");
  endtask : t_boot
  task automatic t_wdt();
    wdt_overflow_in <= 1'b1;
    @(posedge clk_in);
    wdt_overflow_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk(mode, BMSL_MODE_BOOT, "relatched");
    chk(reserved, 1, "reserved");
    xfer(0, `BMSL_OFS_BAUD, 0, 32'h1, 0);
    $display("t_wdt done");
  endtask : t_wdt
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  initial
  begin
    rst(strap, 3);
    t_modes();
    t_regs();
    t_boot();
    t_wdt();
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge clk_in);
    failures++;
    $display("FAIL %0t watchdog expired", $time);
    final_report();
  end
endmodule : bmsl_loader_bench
`default_nettype wire
